//--- src/pmc_mode_ctrl.sv
// Processor mode control register bank with AXI4-Lite access
// Overview of operation
// - Wait insert bit clear gives no wait, set gives one wait state.
// - With wait insert set, internal RAM and ROM accesses get one wait.
// - Flash area select set makes 0F000h to 0FFFFh internal ROM.
// - Flash area select forced to one while CPU rewrite mode is one.
// - Watchdog action select is set by writing one; zero writes ignored.
// - Reserved area expansion set automatically when CPU rewrite mode rises.
// - Memory expansion setting effective only in expansion or microprocessor mode.
// - Expansion or microprocessor mode turns pins into external bus control.
// - Watchdog action clear gives interrupt, set gives device reset.
// - Expansion field 00 is 1-Mbyte, 11 is 4-Mbyte, others unused.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Internal memory access handshake
	input  wire logic        int_access_req,
	output logic             int_access_ready,
	// Address decode for internal ROM window
	input  wire logic [19:0] access_addr,
	output logic             flash_area_hit,
	// Mode outputs
	output logic             wdog_reset_sel,
	output logic             mem_expand_4mb,
	output logic             rsv_area_expand,
	output logic             ext_bus_pins_en
);
	typedef struct packed {
		logic [7:0]  mc1;
		logic        unlock;
		logic        rewrite;
		logic [1:0]  mode;
		logic        aw_got;
		logic [3:0]  aw_addr;
		logic        w_got;
		logic [7:0]  w_data;
		logic        w_strb0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        flash_hit;
		logic        wdog_rst;
		logic        exp4;
		logic        rsv;
		logic        bus_en;
		logic        aw_rdy;
		logic        w_rdy;
		logic        ar_rdy;
	} pmc_state_s;

	pmc_state_s st_ff;
	pmc_state_s nxt_st;
	logic       wait_ready;

	pmc_wait_gen u_wait (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.wait_en     (st_ff.mc1[pmc_pkg::PMC_BIT_WAIT_INSERT]),
		.access_req  (int_access_req),
		.access_ready(wait_ready)
	);

	always_comb begin
		logic       do_write;
		logic [7:0] wv;
		logic       eff_mode;
		do_write = 1'b0;
		wv       = 8'h00;
		eff_mode = 1'b0;
		nxt_st   = st_ff;
		if (s_axi_awvalid && !st_ff.aw_got) begin
			nxt_st.aw_got  = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_ff.w_got) begin
			nxt_st.w_got   = 1'b1;
			nxt_st.w_data  = s_axi_wdata[7:0];
			nxt_st.w_strb0 = s_axi_wstrb[0];
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// Both halves of a write present and no response pending
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = pmc_pkg::PMC_RESP_OKAY;
			do_write      = st_ff.w_strb0;
			wv            = st_ff.w_data;
			if (st_ff.aw_addr == pmc_pkg::PMC_OFF_MODE_CTRL_1) begin
				if (do_write && st_ff.unlock) begin
					nxt_st.mc1 = wv & pmc_pkg::PMC_MC1_WMASK;
					nxt_st.mc1[pmc_pkg::PMC_BIT_WDOG_ACTION] =
						st_ff.mc1[pmc_pkg::PMC_BIT_WDOG_ACTION]
						| wv[pmc_pkg::PMC_BIT_WDOG_ACTION];
				end
			end else if (st_ff.aw_addr == pmc_pkg::PMC_OFF_PROTECT) begin
				if (do_write) begin
					nxt_st.unlock = wv[pmc_pkg::PMC_BIT_PROTECT_UNLOCK];
				end
			end else if (st_ff.aw_addr == pmc_pkg::PMC_OFF_FLASH_CTRL) begin
				if (do_write) begin
					nxt_st.rewrite = wv[pmc_pkg::PMC_BIT_CPU_REWRITE];
				end
			end else if (st_ff.aw_addr == pmc_pkg::PMC_OFF_MODE_CTRL_0) begin
				if (do_write) begin
					nxt_st.mode = wv[1:0];
				end
			end else begin
				nxt_st.bresp = pmc_pkg::PMC_RESP_SLVERR;
			end
		end
		// Rewrite mode rising sets reserved expansion; set wins over write
		if (nxt_st.rewrite && !st_ff.rewrite) begin
			nxt_st.mc1[pmc_pkg::PMC_BIT_RSV_EXPAND] = 1'b1;
		end
		if (nxt_st.rewrite) begin
			nxt_st.mc1[pmc_pkg::PMC_BIT_FLASH_AREA] = 1'b1;
		end
		// Read channel
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_ff.rvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = pmc_pkg::PMC_RESP_OKAY;
			nxt_st.rdata  = 32'h0000_0000;
			if (s_axi_araddr == pmc_pkg::PMC_OFF_MODE_CTRL_1) begin
				nxt_st.rdata[7:0] = st_ff.mc1;
			end else if (s_axi_araddr == pmc_pkg::PMC_OFF_PROTECT) begin
				nxt_st.rdata[pmc_pkg::PMC_BIT_PROTECT_UNLOCK] = st_ff.unlock;
			end else if (s_axi_araddr == pmc_pkg::PMC_OFF_FLASH_CTRL) begin
				nxt_st.rdata[pmc_pkg::PMC_BIT_CPU_REWRITE] = st_ff.rewrite;
			end else if (s_axi_araddr == pmc_pkg::PMC_OFF_MODE_CTRL_0) begin
				nxt_st.rdata[1:0] = st_ff.mode;
			end else begin
				nxt_st.rresp = pmc_pkg::PMC_RESP_SLVERR;
			end
		end
		// Derived outputs, registered
		eff_mode = (nxt_st.mode == pmc_pkg::PMC_MODE_MEM_EXP)
			|| (nxt_st.mode == pmc_pkg::PMC_MODE_MICRO);
		nxt_st.bus_en   = eff_mode;
		nxt_st.exp4     = eff_mode && (nxt_st.mc1[pmc_pkg::PMC_BIT_MEM_EXP_HI:
			pmc_pkg::PMC_BIT_MEM_EXP_LO] == pmc_pkg::PMC_EXP_4MB);
		nxt_st.wdog_rst = nxt_st.mc1[pmc_pkg::PMC_BIT_WDOG_ACTION];
		nxt_st.rsv      = nxt_st.mc1[pmc_pkg::PMC_BIT_RSV_EXPAND];
		nxt_st.flash_hit = nxt_st.mc1[pmc_pkg::PMC_BIT_FLASH_AREA]
			&& (access_addr >= pmc_pkg::PMC_FLASH_AREA_LO)
			&& (access_addr <= pmc_pkg::PMC_FLASH_AREA_HI);
		// Ready flags held in flops so every bus output is registered
		nxt_st.aw_rdy    = !nxt_st.aw_got;
		nxt_st.w_rdy     = !nxt_st.w_got;
		nxt_st.ar_rdy    = !nxt_st.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff     <= '0;
			st_ff.mc1 <= pmc_pkg::PMC_MC1_RESET;
			st_ff.rsv <= 1'b1;
			st_ff.aw_rdy <= 1'b1;
			st_ff.w_rdy  <= 1'b1;
			st_ff.ar_rdy <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign s_axi_awready    = st_ff.aw_rdy;
	assign s_axi_wready     = st_ff.w_rdy;
	assign s_axi_bvalid     = st_ff.bvalid;
	assign s_axi_bresp      = st_ff.bresp;
	assign s_axi_arready    = st_ff.ar_rdy;
	assign s_axi_rvalid     = st_ff.rvalid;
	assign s_axi_rdata      = st_ff.rdata;
	assign s_axi_rresp      = st_ff.rresp;
	assign int_access_ready = wait_ready;
	assign flash_area_hit   = st_ff.flash_hit;
	assign wdog_reset_sel   = st_ff.wdog_rst;
	assign mem_expand_4mb   = st_ff.exp4;
	assign rsv_area_expand  = st_ff.rsv;
	assign ext_bus_pins_en  = st_ff.bus_en;
endmodule : pmc_mode_ctrl
`default_nettype wire

//--- src/pmc_pkg.sv
// Package: offsets, field positions and reset values of the processor mode control bank
package pmc_pkg;
	// Register byte offsets
	localparam logic [3:0] PMC_OFF_MODE_CTRL_1 = 4'h0;
	localparam logic [3:0] PMC_OFF_PROTECT     = 4'h4;
	localparam logic [3:0] PMC_OFF_FLASH_CTRL  = 4'h8;
	localparam logic [3:0] PMC_OFF_MODE_CTRL_0 = 4'hC;
	// Bit positions in processor_mode_control_1
	localparam int PMC_BIT_FLASH_AREA   = 0;
	localparam int PMC_BIT_WDOG_ACTION  = 2;
	localparam int PMC_BIT_RSV_EXPAND   = 3;
	localparam int PMC_BIT_MEM_EXP_LO   = 4;
	localparam int PMC_BIT_MEM_EXP_HI   = 5;
	localparam int PMC_BIT_WAIT_INSERT  = 7;
	// Writable bits (b1 and b6 kept as plain storage, b6 reserved)
	localparam logic [7:0] PMC_MC1_WMASK = 8'hFF;
	localparam logic [7:0] PMC_MC1_RESET = 8'h08;
	// Other bit positions
	localparam int PMC_BIT_PROTECT_UNLOCK = 1;
	localparam int PMC_BIT_CPU_REWRITE    = 1;
	// Processor mode field codes
	localparam logic [1:0] PMC_MODE_SINGLE   = 2'h0;
	localparam logic [1:0] PMC_MODE_MEM_EXP  = 2'h1;
	localparam logic [1:0] PMC_MODE_MICRO    = 2'h3;
	// Memory area expansion codes
	localparam logic [1:0] PMC_EXP_1MB = 2'h0;
	localparam logic [1:0] PMC_EXP_4MB = 2'h3;
	// Internal ROM window opened by the flash area select bit
	localparam logic [19:0] PMC_FLASH_AREA_LO = 20'h0F000;
	localparam logic [19:0] PMC_FLASH_AREA_HI = 20'h0FFFF;
	// AXI responses
	localparam logic [1:0] PMC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;
endpackage : pmc_pkg

//--- src/pmc_wait_gen.sv
// Wait state generator for internal memory accesses
`timescale 1ns/1ps
`default_nettype none
module pmc_wait_gen (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Control
	input  wire logic wait_en,
	input  wire logic access_req,
	// Result
	output logic      access_ready
);
	typedef struct packed {
		logic waited;
		logic ready;
	} pmc_wg_s;

	pmc_wg_s state_ff;
	pmc_wg_s nxt_state;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.ready = 1'b0;
		if (access_req && !state_ff.ready) begin
			if (!wait_en || state_ff.waited) begin
				nxt_state.ready  = 1'b1;
				nxt_state.waited = 1'b0;
			end else begin
				nxt_state.waited = 1'b1;
			end
		end else begin
			nxt_state.waited = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign access_ready = state_ff.ready;
endmodule : pmc_wait_gen
`default_nettype wire

//--- dv/pmc_mode_ctrl_asserts.sv
// Assertion checker for the processor mode control bank
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl_asserts (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Read channel
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Internal access and mode outputs
	input wire logic        int_access_req,
	input wire logic        int_access_ready,
	input wire logic [19:0] access_addr,
	input wire logic        flash_area_hit,
	input wire logic        wdog_reset_sel,
	input wire logic        mem_expand_4mb,
	input wire logic        ext_bus_pins_en
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wdog_sticky_a: assert property (wdog_reset_sel |=> wdog_reset_sel)
		else $error("watchdog select dropped");
	wait_window_a: assert property ($rose(int_access_req) |-> ##[1:2] int_access_ready)
		else $error("access ready late");
	ready_cause_a: assert property (int_access_ready |-> int_access_req)
		else $error("ready without request");
	rom_window_a: assert property (flash_area_hit |-> $past(access_addr[19:12]) == 8'h0F)
		else $error("hit outside window");
	expand_mode_a: assert property (mem_expand_4mb |-> ext_bus_pins_en)
		else $error("expansion outside mode");
	read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data held too long");
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken early");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule : pmc_mode_ctrl_asserts
bind pmc_mode_ctrl pmc_mode_ctrl_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .int_access_req(int_access_req),
	.int_access_ready(int_access_ready), .access_addr(access_addr),
	.flash_area_hit(flash_area_hit), .wdog_reset_sel(wdog_reset_sel),
	.mem_expand_4mb(mem_expand_4mb), .ext_bus_pins_en(ext_bus_pins_en));
`default_nettype wire

//--- dv/processor_mode_ctrl_bits_bench.sv
// Self-checking bench for the processor mode control bank
`timescale 1ns/1ps
`default_nettype none
module processor_mode_ctrl_bits_bench;
	logic        aclk = 0, aresetn = 0, req = 0;
	logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0;
	logic [31:0] wdata = 0, rdata, got;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, rdy, hit, wsel, m4, rsv, pins;
	logic [1:0]  bresp, rresp, md;
	logic [19:0] addr = 0;
	logic [7:0]  m = 8'h08, d;
	logic        ul = 0, rw = 0;
	int          error_cnt = 0, n_compared = 0, seed = 28134, n, i;
	logic [19:0] tab [4] = '{20'h0EFFF, 20'h0F000, 20'h0FFFF, 20'h10000};
	always #20 aclk = ~aclk;
	pmc_mode_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .int_access_req(req), .int_access_ready(rdy),
		.access_addr(addr), .flash_area_hit(hit), .wdog_reset_sel(wsel),
		.mem_expand_4mb(m4), .rsv_area_expand(rsv), .ext_bus_pins_en(pins));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, (a[1:0] != 2'h0) ? 2'h2 : 2'h0);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		got = rdata;
		chk(rresp, (a[1:0] != 2'h0) ? 2'h2 : 2'h0);
	endtask : rd
	// Register write with the bank's model following
	task automatic mw(input logic [7:0] v);
		wr(4'h0, {24'h0, v});
		if (ul) m = (v & 8'hFB) | ((m | v) & 8'h04) | {7'h0, rw};
	endtask : mw
	initial begin
		#400000;
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(4'h0);
		chk(got, 8'h08);
		chk(rsv, 1);
		mw(8'hFF);
		rd(4'h0);
		chk(got, m);
		wr(4'h4, 2);
		ul = 1;
		for (i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			md = 2'($random(seed));
			mw(d);
			wr(4'hC, {30'h0, md});
			rd(4'h0);
			chk(got, m);
			chk(wsel, m[2]);
			chk(pins, md[0]);
			chk(m4, md[0] && m[5:4] == 2'h3);
			rd(4'hC);
			chk(got, {30'h0, md});
		end
		$display("register test done");
		for (i = 0; i < 2; i++) begin
			mw(i ? 8'h80 : 8'h00);
			@(posedge aclk);
			req <= 1'b1;
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (rdy !== 1'b1 && n < 9);
			req <= 1'b0;
			chk(n, 2 + i);
		end
		$display("wait test done");
		mw(8'h01);
		foreach (tab[k]) begin
			@(posedge aclk);
			addr <= tab[k];
			repeat (3) @(posedge aclk);
			chk(hit, tab[k][19:12] == 8'h0F);
		end
		$display("rom window test done");
		mw(8'h00);
		wr(4'h8, 2);
		rw = 1;
		m = m | 8'h09;
		rd(4'h0);
		chk(got, m);
		chk(rsv, 1);
		mw(8'h00);
		rd(4'h0);
		chk(got, m);
		$display("rewrite test done");
		wr(4'h6, 32'h0000_00FF);
		rd(4'h6);
		chk(got, 0);
		rd(4'h4);
		chk(got, 2);
		rd(4'h8);
		chk(got, 2);
		rd(4'h0);
		chk(got, m);
		$display("decode test done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(4'h0);
		chk(got, 8'h08);
		chk(wsel, 0);
		$display("reset test done");
		conclude();
	end
endmodule : processor_mode_ctrl_bits_bench
`default_nettype wire
